// File: core/tpm_map.svh
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH

// Register byte addresses
`define TPM_ADDR_CTRL0      12'h348
`define TPM_ADDR_CTRL1      12'h34c
`define TPM_ADDR_TIMING     12'h350
`define TPM_ADDR_CARRIER    12'h354
`define TPM_ADDR_DEADTIME   12'h358
`define TPM_ADDR_U_WIDTH    12'h35c
`define TPM_ADDR_V_WIDTH    12'h360
`define TPM_ADDR_W_WIDTH    12'h364
`define TPM_ADDR_U_WIDTH2   12'h368
`define TPM_ADDR_V_WIDTH2   12'h36c
`define TPM_ADDR_W_WIDTH2   12'h370
`define TPM_ADDR_BUFFER     12'h374
`define TPM_ADDR_IRQ_STAT   12'h378
`define TPM_ADDR_IRQ_MASK   12'h37c

// Control 0 fields
`define TPM_C0_EDGE         0
`define TPM_C0_SRC          1
`define TPM_C0_FEN          2
`define TPM_C0_OEN          3
`define TPM_C0_CAD          4
`define TPM_C0_DET          5
`define TPM_C0_MOD          6
`define TPM_C0_TRIG         7

// Control 1 fields
`define TPM_C1_START        0
`define TPM_C1_SECOND       1
`define TPM_C1_POL          4
`define TPM_C1_DTDIS        5
`define TPM_C1_NMICUT       8

// Timing register fields
`define TPM_TM_RUN          0
`define TPM_TM_DEC_LO       4
`define TPM_TM_DEC_HI       7

// Interrupt status bits
`define TPM_IRQ_CARRIER     0
`define TPM_IRQ_DETECT      1
`define TPM_IRQ_CUTOFF      2

// Reset values
`define TPM_RST_CTRL0       8'h00
`define TPM_RST_CTRL1       9'h000
`define TPM_RST_WIDTH       16'h0001
`define TPM_RST_DEAD        8'h01

`endif

// File: core/tpm_pkg.sv
package tpm_pkg;

  // Per-phase output pair
  typedef struct packed {
    logic pos;
    logic neg;
  } tpm_pair_t;

  typedef struct packed {
    tpm_pair_t u;
    tpm_pair_t v;
    tpm_pair_t w;
  } tpm_phases_t;

  // Triangular count direction walks down then up
  typedef enum logic [1:0] {
    TPM_IDLE = 2'b00,
    TPM_DOWN = 2'b01,
    TPM_UP   = 2'b11
  } tpm_state_t;

endpackage

// File: core/tpm_core.sv
// Function
// - Six outputs, three pairs, carrier timer
// - Carrier period (m+1), doubled triangular
// - Phase width n periods, doubled triangular
// - Second mode alternates two width values, triangular only
// - Dead time p periods, or disabled
// - Carrier interrupt every N cycles, N<=15
// - Cutoff enable plus low pin: hi-Z
// - Edge count on V reload, edge select
// - Source select: underflow or selected edge, edge only in second mode
// - Output enable cleared by two causes: pin fall, or concurrent active pair with disable bit set
// - Disable bit forbids concurrent active pair
// - Detect flag hardware set, clear needs disable written zero
// - Modulation select: triangular or sawtooth
// - Software trigger bit, reads zero
// - Per-side levels, selectable active level
// - Transfer trigger: underflow after write
// - Buffer to shift register transfer timing
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tpm_map.svh"

module tpm_core #(
  parameter int DT_W  = 8,
  parameter int CNT_W = 16
) (
  input  wire logic        pclk,          // APB clock, 200 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB direction
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped
  input  wire logic        nmi_n,         // Cutoff pin, active low
  output logic      [5:0]  phase_out,     // U,Ub,V,Vb,W,Wb levels
  output logic      [5:0]  phase_oe_n,    // Pin enables, low drives
  output logic             irq            // Level interrupt
);

  initial begin
    if (DT_W != 8 || CNT_W != 16) $error("tpm_core: unsupported widths");
  end

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [7:0]       ctrl0_q;
  logic [8:0]       ctrl1_q;
  logic [7:0]       timing_q;
  logic [CNT_W-1:0] carrier_q;
  logic [DT_W-1:0]  dead_q;
  logic [CNT_W-1:0] width_q  [0:2];
  logic [CNT_W-1:0] width2_q [0:2];
  logic [11:0]      buf_q;
  logic [2:0]       irq_stat_q;
  logic [2:0]       irq_mask_q;
  logic [11:0]      shift_q;

  logic acc, wr, rd;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  logic hit;
  always_comb begin
    case (paddr)
      `TPM_ADDR_CTRL0, `TPM_ADDR_CTRL1, `TPM_ADDR_TIMING, `TPM_ADDR_CARRIER,
      `TPM_ADDR_DEADTIME, `TPM_ADDR_U_WIDTH, `TPM_ADDR_V_WIDTH, `TPM_ADDR_W_WIDTH,
      `TPM_ADDR_U_WIDTH2, `TPM_ADDR_V_WIDTH2, `TPM_ADDR_W_WIDTH2, `TPM_ADDR_BUFFER,
      `TPM_ADDR_IRQ_STAT, `TPM_ADDR_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  logic wr_c0, wr_car, wr_buf;
  assign wr_c0  = wr && paddr == `TPM_ADDR_CTRL0;
  assign wr_car = wr && paddr == `TPM_ADDR_CARRIER;
  assign wr_buf = wr && paddr == `TPM_ADDR_BUFFER;

  // Every access completes in one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // Read data registered in setup phase; stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TPM_ADDR_CTRL0:    prdata <= {24'h00_0000, 1'b0, ctrl0_q[6:0]};
        `TPM_ADDR_CTRL1:    prdata <= {23'h00_0000, ctrl1_q};
        `TPM_ADDR_TIMING:   prdata <= {24'h00_0000, timing_q};
        `TPM_ADDR_CARRIER:  prdata <= {16'h0000, carrier_q};
        `TPM_ADDR_DEADTIME: prdata <= {24'h00_0000, dead_q};
        `TPM_ADDR_U_WIDTH:  prdata <= {16'h0000, width_q[0]};
        `TPM_ADDR_V_WIDTH:  prdata <= {16'h0000, width_q[1]};
        `TPM_ADDR_W_WIDTH:  prdata <= {16'h0000, width_q[2]};
        `TPM_ADDR_U_WIDTH2: prdata <= {16'h0000, width2_q[0]};
        `TPM_ADDR_V_WIDTH2: prdata <= {16'h0000, width2_q[1]};
        `TPM_ADDR_W_WIDTH2: prdata <= {16'h0000, width2_q[2]};
        // Reads return the live shift register
        `TPM_ADDR_BUFFER:   prdata <= {20'h0_0000, shift_q};
        `TPM_ADDR_IRQ_STAT: prdata <= {29'h0000_0000, irq_stat_q};
        `TPM_ADDR_IRQ_MASK: prdata <= {29'h0000_0000, irq_mask_q};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q    <= `TPM_RST_CTRL1;
      timing_q   <= 8'h00;
      carrier_q  <= '0;
      dead_q     <= `TPM_RST_DEAD;
      width_q    <= '{default: `TPM_RST_WIDTH};
      width2_q   <= '{default: `TPM_RST_WIDTH};
      buf_q      <= 12'h000;
      irq_mask_q <= 3'h0;
    end else if (wr) begin
      case (paddr)
        `TPM_ADDR_CTRL1:    ctrl1_q    <= pwdata[8:0];
        `TPM_ADDR_TIMING:   timing_q   <= pwdata[7:0];
        `TPM_ADDR_CARRIER:  carrier_q  <= pwdata[15:0];
        // Reload 01h..FFh; zero kept at one
        `TPM_ADDR_DEADTIME: dead_q     <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        `TPM_ADDR_U_WIDTH:  width_q[0] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_V_WIDTH:  width_q[1] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_W_WIDTH:  width_q[2] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_U_WIDTH2: width2_q[0] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_V_WIDTH2: width2_q[1] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_W_WIDTH2: width2_q[2] <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `TPM_ADDR_BUFFER:   buf_q      <= pwdata[11:0];
        `TPM_ADDR_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default:            ctrl1_q    <= ctrl1_q;
      endcase
    end
  end

  logic fen, sawtooth, second, pol, dtdis, run;
  assign fen      = ctrl0_q[`TPM_C0_FEN];
  assign sawtooth = ctrl0_q[`TPM_C0_MOD];
  assign second   = ctrl1_q[`TPM_C1_SECOND] && !sawtooth;
  assign pol      = ctrl1_q[`TPM_C1_POL];
  assign dtdis    = ctrl1_q[`TPM_C1_DTDIS];
  assign run      = timing_q[`TPM_TM_RUN];

  // ==========================================================
  // Carrier timer
  // ==========================================================
  logic [CNT_W-1:0] car_cnt_q;
  logic             car_up_q;
  logic             car_uf;

  // Sawtooth reloads; triangular counts down twice, up flag marks second pass
  assign car_uf = run && car_cnt_q == '0 && (sawtooth || car_up_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_cnt_q <= '0;
      car_up_q  <= 1'b0;
    end else if (!run) begin
      car_cnt_q <= carrier_q;
      car_up_q  <= 1'b0;
    end else if (sawtooth) begin
      car_cnt_q <= (car_cnt_q == '0) ? carrier_q : car_cnt_q - 16'h0001;
    end else if (!car_up_q) begin
      if (car_cnt_q == '0) begin
        car_cnt_q <= carrier_q;
        car_up_q  <= 1'b1;
      end else begin
        car_cnt_q <= car_cnt_q - 16'h0001;
      end
    end else begin
      if (car_cnt_q == '0) begin
        car_cnt_q <= carrier_q;
        car_up_q  <= 1'b0;
      end else begin
        car_cnt_q <= car_cnt_q - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Triggers and shift register
  // ==========================================================
  logic sw_pend_q, xfer, xfer_pend_q;

  // Write of one arms a transfer trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pend_q <= 1'b0;
    end else if (wr_c0 && pwdata[`TPM_C0_TRIG]) begin
      sw_pend_q <= 1'b1;
    end else if (car_uf) begin
      sw_pend_q <= 1'b0;
    end
  end

  // Underflow after software write, or carrier write with start bit set
  assign xfer = (car_uf && sw_pend_q) || (wr_car && ctrl1_q[`TPM_C1_START]);

  // Triangular moves once per buffer write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_pend_q <= 1'b0;
    end else if (wr_buf) begin
      xfer_pend_q <= 1'b1;
    end else if (xfer) begin
      xfer_pend_q <= 1'b0;
    end
  end

  // Both halves move together; the one-shot picks which half drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 12'hfff;
    end else if (xfer && (sawtooth || xfer_pend_q)) begin
      shift_q <= buf_q;
    end
  end

  // ==========================================================
  // Phase one-shots and dead time
  // ==========================================================
  tpm_pkg::tpm_phases_t raw;
  logic [CNT_W-1:0] ph_cnt_q [0:2];
  logic [DT_W-1:0]  dt_cnt_q [0:2];
  logic [2:0]       ph_act;
  logic [2:0]       half_q;
  logic [2:0]       dt_on;

  // One one-shot per phase pair, started by carrier
  for (genvar i = 0; i < 3; i++) begin : g_ph
    logic [CNT_W-1:0] n;
    // Alternate width value in second mode
    assign n = (second && half_q[i]) ? width2_q[i] : width_q[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ph_cnt_q[i] <= '0;
        half_q[i]   <= 1'b0;
      end else if (!fen || !run) begin
        ph_cnt_q[i] <= '0;
        half_q[i]   <= 1'b0;
      // Width n; doubled in triangular by loading n shifted left by one
      end else if (car_uf) begin
        ph_cnt_q[i] <= sawtooth ? n : 16'(n << 1);
        half_q[i]   <= !half_q[i];
      end else if (ph_cnt_q[i] != '0) begin
        ph_cnt_q[i] <= ph_cnt_q[i] - 16'h0001;
      end
    end
    assign ph_act[i] = ph_cnt_q[i] != '0;

    // Dead time after each edge of the one-shot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dt_cnt_q[i] <= '0;
      end else if (!fen) begin
        dt_cnt_q[i] <= '0;
      end else if (!dtdis && (car_uf || (ph_cnt_q[i] == 16'h0001) || (sawtooth && xfer))) begin
        dt_cnt_q[i] <= dead_q;
      end else if (dt_cnt_q[i] != '0) begin
        dt_cnt_q[i] <= dt_cnt_q[i] - 8'h01;
      end
    end
    assign dt_on[i] = dt_cnt_q[i] != '0;
  end

  // Shift bits: 0 active level per side
  // Sides set independently, so software can make a pair overlap
  always_comb begin
    raw.u.pos = !(ph_act[0] ? shift_q[0] : shift_q[6]) && !dt_on[0];
    raw.u.neg = !(ph_act[0] ? shift_q[1] : shift_q[7]) && !dt_on[0];
    raw.v.pos = !(ph_act[1] ? shift_q[2] : shift_q[8]) && !dt_on[1];
    raw.v.neg = !(ph_act[1] ? shift_q[3] : shift_q[9]) && !dt_on[1];
    raw.w.pos = !(ph_act[2] ? shift_q[4] : shift_q[10]) && !dt_on[2];
    raw.w.neg = !(ph_act[2] ? shift_q[5] : shift_q[11]) && !dt_on[2];
  end

  logic conc;
  assign conc = (raw.u.pos && raw.u.neg) || (raw.v.pos && raw.v.neg) || (raw.w.pos && raw.w.neg);

  // ==========================================================
  // Control 0 and protection
  // ==========================================================
  logic nmi_q, nmi_fall, cutoff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nmi_q <= 1'b1;
    else          nmi_q <= nmi_n;
  end
  assign nmi_fall = nmi_q && !nmi_n;
  assign cutoff = ctrl1_q[`TPM_C1_NMICUT] && !nmi_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= `TPM_RST_CTRL0;
    end else begin
      if (wr_c0) begin
        ctrl0_q[4:0] <= pwdata[4:0];
        ctrl0_q[6]   <= pwdata[6];
      end
      // Output enable cleared by pin fall, or by conflict while disable bit set
      if (nmi_fall || (conc && ctrl0_q[`TPM_C0_CAD])) begin
        ctrl0_q[`TPM_C0_OEN] <= 1'b0;
      end
      // Set beats clear; clear needs disable written zero
      if (conc && fen) begin
        ctrl0_q[`TPM_C0_DET] <= 1'b1;
      end else if (wr_c0 && !pwdata[`TPM_C0_DET] && !pwdata[`TPM_C0_CAD]) begin
        ctrl0_q[`TPM_C0_DET] <= 1'b0;
      end
      ctrl0_q[`TPM_C0_TRIG] <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  tpm_pkg::tpm_phases_t gated;
  always_comb begin
    gated = raw;
    if (ctrl0_q[`TPM_C0_CAD]) begin
      if (raw.u.pos && raw.u.neg) gated.u = '0;
      if (raw.v.pos && raw.v.neg) gated.v = '0;
      if (raw.w.pos && raw.w.neg) gated.w = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_out  <= 6'h00;
      phase_oe_n <= 6'h3f;
    end else begin
      // Active level chosen by polarity bit
      phase_out  <= pol ? 6'(gated) : ~6'(gated);
      // Drive only with function and output enable
      phase_oe_n <= (fen && ctrl0_q[`TPM_C0_OEN] && !cutoff) ? 6'h00 : 6'h3f;
    end
  end

  // ==========================================================
  // Decimation counter and interrupts
  // ==========================================================
  logic [3:0] dec_q;
  logic       vact_q, dec_ev, car_irq;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vact_q <= 1'b0;
    else          vact_q <= ph_act[1];
  end

  // Underflow, or edge when source select set in second mode
  // Rising V reload edge on 0, falling on 1
  always_comb begin
    if (ctrl0_q[`TPM_C0_SRC] && second) begin
      dec_ev = ctrl0_q[`TPM_C0_EDGE] ? (vact_q && !ph_act[1]) : (!vact_q && ph_act[1]);
    end else begin
      dec_ev = car_uf;
    end
  end

  // Fire at programmed count, restart from zero
  // Count includes this event, so N events per request
  assign car_irq = fen && dec_ev && (({1'b0, dec_q} + 5'h01) >= {1'b0, timing_q[`TPM_TM_DEC_HI:`TPM_TM_DEC_LO]});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)     dec_q <= 4'h0;
    else if (!fen)    dec_q <= 4'h0;
    else if (car_irq) dec_q <= 4'h0;
    else if (dec_ev)  dec_q <= dec_q + 4'h1;
  end

  // Sticky status; set wins over write-one clear
  logic [2:0] ev;
  assign ev = {cutoff, conc && fen, car_irq};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= ev | (irq_stat_q & ~((wr && paddr == `TPM_ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= |(ev | (irq_stat_q & irq_mask_q)) && |((ev | irq_stat_q) & irq_mask_q);
  end

endmodule

// File: dv/tpm_core_monitor.sv
`timescale 1ns/1ps
`include "tpm_map.svh"

// ==========================================================
// Port checker
module tpm_core_monitor #(
  parameter int DT_W  = 8,
  parameter int CNT_W = 16
) (
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, active low
  input wire logic        psel,       // Select
  input wire logic        penable,    // Access phase
  input wire logic        pwrite,     // Direction
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Write data
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        nmi_n,      // Cutoff pin
  input wire logic [5:0]  phase_out,  // Phase levels
  input wire logic [5:0]  phase_oe_n, // Pin enables
  input wire logic        irq         // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic mapped;
  assign mapped = paddr inside {`TPM_ADDR_CTRL0, `TPM_ADDR_CTRL1, `TPM_ADDR_TIMING, `TPM_ADDR_CARRIER,
                                `TPM_ADDR_DEADTIME, `TPM_ADDR_U_WIDTH, `TPM_ADDR_V_WIDTH, `TPM_ADDR_W_WIDTH,
                                `TPM_ADDR_U_WIDTH2, `TPM_ADDR_V_WIDTH2, `TPM_ADDR_W_WIDTH2,
                                `TPM_ADDR_BUFFER, `TPM_ADDR_IRQ_STAT, `TPM_ADDR_IRQ_MASK};

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pin_fall;
    $fell(nmi_n);
  endsequence
  sequence s_all_float;
    ##[1:4] (phase_oe_n == 6'h3f);
  endsequence

  a_ready_zero_wait: assert property (s_setup |=> pready) else $error("no answer in access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_has_cause: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_on_hole: assert property (s_setup ##0 !mapped |=> pslverr) else $error("hole not refused");
  a_err_mapped_ok: assert property (s_setup ##0 mapped |=> !pslverr) else $error("mapped refused");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("hole read");
  a_cutoff_float: assert property (s_pin_fall |-> s_all_float) else $error("pins driven after pin fall");
  a_enable_together: assert property (phase_oe_n inside {6'h00, 6'h3f}) else $error("split enables");
  a_trigger_reads_zero: assert property (s_setup ##0 (!pwrite && paddr == `TPM_ADDR_CTRL0)
                                         |=> !prdata[`TPM_C0_TRIG]) else $error("trigger bit read");
endmodule

bind tpm_core tpm_core_monitor #(.DT_W(DT_W), .CNT_W(CNT_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_n(nmi_n),
  .phase_out(phase_out), .phase_oe_n(phase_oe_n), .irq(irq)
);

// File: dv/tpm_gate_model.sv
`timescale 1ns/1ps

// ==========================================================
// Gate driver stand-in
module tpm_gate_model (
  input  wire logic       pclk,       // Clock
  input  wire logic [5:0] phase_out,  // Levels from block
  input  wire logic [5:0] phase_oe_n, // Low drives pin
  output logic      [5:0] pin         // Level at driver input
);
  logic [5:0] last_q;

  always_ff @(posedge pclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!phase_oe_n[i]) begin
        last_q[i] <= phase_out[i];
      end
    end
  end

  // floating pins
  // Released pin shows inverse, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin[i] = phase_oe_n[i] ? ~last_q[i] : phase_out[i];
    end
  end
endmodule

// File: dv/three_phase_motor_pwm_test.sv
`timescale 1ns/1ps
`include "tpm_map.svh"

module three_phase_motor_pwm_test;
  logic        pclk, presetn, psel, penable, pwrite, nmi_n, pready, pslverr, irq, last_err, ia;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  phase_out, phase_oe_n, pin;
  int          n_mismatch, checks_done, cyc, seed, t0, t1, m, n;

  tpm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_n(nmi_n),
    .phase_out(phase_out), .phase_oe_n(phase_oe_n), .irq(irq));
  tpm_gate_model u_gate (.pclk(pclk), .phase_out(phase_out), .phase_oe_n(phase_oe_n), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================================
  // Bus and checks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    checks_done++;
    if (got < exp - 8 || got > exp + 8) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_oe(input logic [5:0] v);
    int k;
    k = 0;
    while (phase_oe_n !== v && k < 3000) begin @(posedge pclk); k++; end
    chk(32'(phase_oe_n), 32'(v));
  endtask
  // Polling granularity is one bus cycle, so spans carry a small slack
  task automatic wait_carrier(output int t);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && k < 3000) begin apb(1'b0, `TPM_ADDR_IRQ_STAT, 32'h0); k++; end
    t = cyc;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish;
  end

  // ==========================================================
  // Scenarios
  initial begin
    seed = 32'h9bac;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; nmi_n = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(phase_oe_n), 32'h3f);
    apb(1'b0, `TPM_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `TPM_ADDR_CTRL0, 32'ha0);
    apb(1'b0, `TPM_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h380, 32'h0);
    chk({rd[31:1], last_err}, 32'h1);
    $display("reset and map test done");

    apb(1'b1, `TPM_ADDR_BUFFER, 32'hfff);
    apb(1'b1, `TPM_ADDR_CARRIER, 32'd40);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `TPM_ADDR_TIMING, 32'h0);
      apb(1'b1, `TPM_ADDR_CTRL0, 32'h0);
      apb(1'b1, `TPM_ADDR_CTRL1, 32'(p) << 4);
      apb(1'b1, `TPM_ADDR_TIMING, 32'h1);
      apb(1'b1, `TPM_ADDR_CTRL0, 32'h08);
      repeat (4) @(posedge pclk);
      chk(32'(phase_oe_n), 32'h3f);
      apb(1'b1, `TPM_ADDR_CTRL0, 32'h9c);
      wait_oe(6'h00);
      repeat (300) @(posedge pclk);
      chk(32'(pin), p ? 32'h00 : 32'h3f);
    end
    $display("polarity test done");

    apb(1'b1, `TPM_ADDR_CTRL1, 32'h110);
    nmi_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(phase_oe_n), 32'h3f);
    apb(1'b0, `TPM_ADDR_CTRL0, 32'h0);
    chk(32'(rd[`TPM_C0_OEN]), 32'h0);
    // Output enable set again; a low pin must still float every pin
    apb(1'b1, `TPM_ADDR_CTRL0, 32'h0c);
    repeat (4) @(posedge pclk);
    chk(32'(phase_oe_n), 32'h3f);
    nmi_n <= 1'b1;
    wait_oe(6'h00);
    $display("cutoff test done");

    apb(1'b1, `TPM_ADDR_IRQ_STAT, 32'h7);
    apb(1'b1, `TPM_ADDR_BUFFER, 32'h0);
    apb(1'b1, `TPM_ADDR_CTRL0, 32'h9c);
    wait_oe(6'h00);
    wait_oe(6'h3f);
    apb(1'b0, `TPM_ADDR_CTRL0, 32'h0);
    chk(rd & 32'h28, 32'h20);
    apb(1'b1, `TPM_ADDR_TIMING, 32'h0);
    apb(1'b1, `TPM_ADDR_IRQ_STAT, 32'h5);
    apb(1'b1, `TPM_ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    ia = irq;
    apb(1'b1, `TPM_ADDR_IRQ_MASK, 32'h5);
    repeat (2) @(posedge pclk);
    chk(32'(ia ^ irq), 32'h1);
    apb(1'b1, `TPM_ADDR_BUFFER, 32'hfff);
    apb(1'b1, `TPM_ADDR_TIMING, 32'h1);
    apb(1'b1, `TPM_ADDR_CTRL0, 32'h84);
    repeat (300) @(posedge pclk);
    apb(1'b1, `TPM_ADDR_CTRL0, 32'h04);
    apb(1'b0, `TPM_ADDR_CTRL0, 32'h0);
    chk(32'(rd[`TPM_C0_DET]), 32'h0);
    apb(1'b1, `TPM_ADDR_TIMING, 32'h0);
    apb(1'b1, `TPM_ADDR_IRQ_STAT, 32'h7);
    apb(1'b1, `TPM_ADDR_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("concurrent test done");

    for (int i = 0; i < 4; i++) begin
      m = 16 + ($unsigned($random(seed)) % 24);
      n = 1 + ($unsigned($random(seed)) % 15);
      apb(1'b1, `TPM_ADDR_TIMING, 32'h0);
      apb(1'b1, `TPM_ADDR_CTRL0, 32'h04 | (32'(i % 2) << 6));
      apb(1'b1, `TPM_ADDR_CARRIER, 32'(m));
      apb(1'b1, `TPM_ADDR_TIMING, (32'(n) << 4) | 32'h1);
      apb(1'b1, `TPM_ADDR_IRQ_STAT, 32'h1);
      wait_carrier(t0);
      apb(1'b1, `TPM_ADDR_IRQ_STAT, 32'h1);
      wait_carrier(t1);
      chk_near(t1 - t0, n * (m + 1) * ((i % 2) ? 1 : 2));
    end
    $display("decimation test done");
    tally_and_finish;
  end
endmodule
